// >>> shared/radar_framer_regs.vh
// constants for the radar process data framer: frame layout, parameter map, codes
// assumes inclusion by bare name from the design file
`ifndef RADAR_FRAMER_REGS_VH
`define RADAR_FRAMER_REGS_VH
// parameter group of the cyclic frame
`define PGN_PROCESS_DATA      16'hff20
// byte positions inside the 64-bit frame
`define BYTE_DIST_LO         3'h0
`define BYTE_DIST_HI         3'h1
`define BYTE_AZIMUTH         3'h2
`define BYTE_ELEVATION       3'h3
`define BYTE_VELOCITY        3'h4
`define BYTE_STRENGTH        3'h5
`define BYTE_FLAGS           3'h6
`define BYTE_FIELDS          3'h7
// bit positions in the flag and field bytes
`define BIT_NO_DATA          3'h0
`define BIT_RADIUS_BASE      3'h2
`define BIT_INT_ERROR        3'h0
`define BIT_FIELD_BASE       3'h2
// object selection
`define SEL_NEAREST          1'h0
`define SEL_STRONGEST        1'h1
// parameter indices: channel c base index, next index for logic/mode/hysteresis
`define IDX_SW_CH2_2_SP      16'h400e
`define IDX_SW_CH2_2_CFG     16'h400f
`define IDX_SW_CH3_1_SP      16'h401c
`define IDX_SW_CH3_1_CFG     16'h401d
`define IDX_SW_CH3_2_SP      16'h401e
`define IDX_SW_CH3_2_CFG     16'h401f
`define IDX_SW_CH4_1_SP      16'h402c
`define IDX_SW_CH4_1_CFG     16'h402d
`define IDX_SW_CH4_2_SP      16'h402e
`define IDX_SW_CH4_2_CFG     16'h402f
`define SUB_SETPOINT_A       8'h01
`define SUB_SETPOINT_B       8'h02
`define SUB_CONTACT_LOGIC    8'h01
`define SUB_SWITCH_MODE      8'h02
`define SUB_HYSTERESIS       8'h03
// switching modes and contact logic
`define MODE_OFF             2'h0
`define MODE_SINGLE_POINT    2'h1
`define MODE_WINDOW          2'h2
`define MODE_TWO_POINT       2'h3
`define LOGIC_NORMALLY_OPEN  1'h0
`define LOGIC_NORMALLY_CLOSED 1'h1
// reset values of the channel parameters
`define RST_SETPOINT         16'h0000
`define RST_HYSTERESIS       16'h0000
`define RST_BYTE             8'h00
`define NUM_CHANNELS         5
`endif

// >>> hw/radar_process_data_framer.v
// radar process data framer: builds the 64-bit cyclic frame and holds
// the switching channel parameter bank, read and written by index/subindex.
// assumes all inputs synchronous to clk_sys; frame_tx_ready from the can side.
//
// Summary of operation
// RULE1 - 64-bit frame sent with group ff20
// RULE2 - bytes 0-1 carry distance, 1 mm/bit
// RULE3 - byte 2 carries azimuth, 0.5 deg/bit
// RULE4 - byte 3 carries elevation, 0.5 deg/bit
// RULE5 - byte 4 carries signed velocity, 0.1 m/s
// RULE6 - byte 5 carries signal strength, 2%/bit
// RULE7 - byte 6 bit 0 set when no object
// RULE8 - byte 6 bits 2-7 radii 1-6, bit 1 reserved
// RULE9 - byte 7 three fields, error bit 0
// RULE10 - field code: shaded bit, collision bit
// RULE11 - report nearest or strongest object, selectable
// RULE12 - mode 0 off,1 single,2 window,3 two-point
// RULE13 - logic 0 normally open, 1 normally closed
// RULE14 - setpoints at base index, config next index
// RULE15 - distance sent low byte first
// RULE16 - angles and velocity two's complement signed
`include "radar_framer_regs.vh"
`default_nettype none
module radar_process_data_framer (
  // clock, reset, enable
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        clk_en,
  // nearest object measurement
  input  wire [15:0] near_distance,
  input  wire [7:0]  near_azimuth,
  input  wire [7:0]  near_elevation,
  input  wire [7:0]  near_velocity,
  input  wire [7:0]  near_strength,
  // strongest object measurement
  input  wire [15:0] strong_distance,
  input  wire [7:0]  strong_azimuth,
  input  wire [7:0]  strong_elevation,
  input  wire [7:0]  strong_velocity,
  input  wire [7:0]  strong_strength,
  // status from detection
  input  wire        object_valid,
  input  wire [5:0]  radius_hit,
  input  wire [2:0]  field_shaded,
  input  wire [2:0]  field_collision,
  input  wire        internal_error,
  input  wire        object_select,
  // cycle strobe and can side handshake
  input  wire        cycle_tick,
  input  wire        frame_tx_ready,
  output wire        frame_tx_valid,
  output reg  [63:0] frame_data,
  output wire [15:0] frame_pgn,
  // parameter access by index and subindex
  input  wire        param_wr,
  input  wire        param_rd,
  input  wire [15:0] param_index,
  input  wire [7:0]  param_subindex,
  input  wire [15:0] param_wdata,
  output reg  [15:0] param_rdata,
  output reg         param_ack,
  output reg         param_err,
  // decoded channel configuration
  output wire [9:0]  channel_mode,
  output wire [4:0]  channel_nc
);

  // ===========================================================
  // frame builder
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  reg        state_reg;
  reg        state_next;
  reg [63:0] frame_next;

  wire        sel_strong = (object_select == `SEL_STRONGEST);  // RULE11
  wire [15:0] m_dist = sel_strong ? strong_distance  : near_distance;
  wire [7:0]  m_azi  = sel_strong ? strong_azimuth   : near_azimuth;
  wire [7:0]  m_elev = sel_strong ? strong_elevation : near_elevation;
  wire [7:0]  m_velo = sel_strong ? strong_velocity  : near_velocity;
  wire [7:0]  m_sig  = sel_strong ? strong_strength  : near_strength;

  wire [7:0]  flag_byte;
  wire [7:0]  field_byte;
  assign flag_byte = {radius_hit, 1'b0, ~object_valid};                  // RULE7 RULE8
  // per field: lower bit shaded, upper bit collision
  assign field_byte = {field_collision[2], field_shaded[2],
                       field_collision[1], field_shaded[1],
                       field_collision[0], field_shaded[0],
                       1'b0, internal_error};                            // RULE9 RULE10

  assign frame_pgn      = `PGN_PROCESS_DATA;                             // RULE1
  assign frame_tx_valid = (state_reg == ST_SEND);

  always @*
  begin
    state_next = state_reg;
    frame_next = frame_data;
    case (state_reg)
      ST_IDLE:
      begin
        if (cycle_tick)
        begin
          // capture one consistent snapshot per cycle; byte 0 is bits 7:0
          // so the distance low byte lands in byte 0, high byte in byte 1
          frame_next = {field_byte, flag_byte, m_sig, m_velo,
                        m_elev, m_azi, m_dist[15:8], m_dist[7:0]};       // RULE2 RULE3 RULE4 RULE5 RULE6 RULE15 RULE16
          state_next = ST_SEND;
        end
      end
      ST_SEND:
      begin
        // a tick while waiting is dropped; the frame stays stable
        if (frame_tx_ready)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg  <= ST_IDLE;
      frame_data <= 64'h0000000000000000;
    end
    else if (clk_en)
    begin
      state_reg  <= state_next;
      frame_data <= frame_next;
    end
  end

  // ===========================================================
  // switching channel parameter bank
  reg [15:0] sp_a_reg  [0:`NUM_CHANNELS-1];
  reg [15:0] sp_b_reg  [0:`NUM_CHANNELS-1];
  reg [15:0] hyst_reg  [0:`NUM_CHANNELS-1];
  reg [7:0]  logic_reg [0:`NUM_CHANNELS-1];
  reg [7:0]  mode_reg  [0:`NUM_CHANNELS-1];

  wire [`NUM_CHANNELS-1:0] hit_sp;
  wire [`NUM_CHANNELS-1:0] hit_cfg;

  function [15:0] sp_index;
    input integer ch;
    begin
      case (ch)
        0:       sp_index = `IDX_SW_CH2_2_SP;
        1:       sp_index = `IDX_SW_CH3_1_SP;
        2:       sp_index = `IDX_SW_CH3_2_SP;
        3:       sp_index = `IDX_SW_CH4_1_SP;
        default: sp_index = `IDX_SW_CH4_2_SP;
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `NUM_CHANNELS; g = g + 1)
    begin : gen_ch
      // config index always follows the setpoint index
      assign hit_sp[g]  = (param_index == sp_index(g));                  // RULE14
      assign hit_cfg[g] = (param_index == sp_index(g) + 16'h0001);       // RULE14
      assign channel_mode[2*g+1:2*g] = mode_reg[g][1:0];                 // RULE12
      assign channel_nc[g] = (logic_reg[g][0] == `LOGIC_NORMALLY_CLOSED); // RULE13

      always @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          sp_a_reg[g]  <= `RST_SETPOINT;
          sp_b_reg[g]  <= `RST_SETPOINT;
          hyst_reg[g]  <= `RST_HYSTERESIS;
          logic_reg[g] <= `RST_BYTE;
          mode_reg[g]  <= `RST_BYTE;
        end
        else if (clk_en && param_wr)
        begin
          if (hit_sp[g] && param_subindex == `SUB_SETPOINT_A)
            sp_a_reg[g] <= param_wdata;
          if (hit_sp[g] && param_subindex == `SUB_SETPOINT_B)
            sp_b_reg[g] <= param_wdata;
          // only the defined codes are stored: 1 bit logic, 2 bit mode
          if (hit_cfg[g] && param_subindex == `SUB_CONTACT_LOGIC)
            logic_reg[g] <= {7'h00, param_wdata[0]};                    // RULE13
          if (hit_cfg[g] && param_subindex == `SUB_SWITCH_MODE)
            mode_reg[g] <= {6'h00, param_wdata[1:0]};                   // RULE12
          if (hit_cfg[g] && param_subindex == `SUB_HYSTERESIS)
            hyst_reg[g] <= param_wdata;
        end
      end
    end
  endgenerate

  // read mux and access answer
  reg [15:0] rdata_next;
  reg        found_next;
  integer    i;

  always @*
  begin
    rdata_next = 16'h0000;
    found_next = 1'b0;
    for (i = 0; i < `NUM_CHANNELS; i = i + 1)
    begin
      if (hit_sp[i] && param_subindex == `SUB_SETPOINT_A)
      begin
        rdata_next = sp_a_reg[i];
        found_next = 1'b1;
      end
      if (hit_sp[i] && param_subindex == `SUB_SETPOINT_B)
      begin
        rdata_next = sp_b_reg[i];
        found_next = 1'b1;
      end
      if (hit_cfg[i] && param_subindex == `SUB_CONTACT_LOGIC)
      begin
        rdata_next = {8'h00, logic_reg[i]};
        found_next = 1'b1;
      end
      if (hit_cfg[i] && param_subindex == `SUB_SWITCH_MODE)
      begin
        rdata_next = {8'h00, mode_reg[i]};
        found_next = 1'b1;
      end
      if (hit_cfg[i] && param_subindex == `SUB_HYSTERESIS)
      begin
        rdata_next = hyst_reg[i];
        found_next = 1'b1;
      end
    end
  end

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      param_rdata <= 16'h0000;
      param_ack   <= 1'b0;
      param_err   <= 1'b0;
    end
    else if (clk_en)
    begin
      param_ack <= param_wr | param_rd;
      param_err <= (param_wr | param_rd) & ~found_next;
      if (param_rd)
        param_rdata <= rdata_next;
    end
  end

endmodule
`default_nettype wire

// >>> sim/radar_framer_asserts.sv
// checker for the framer ports: frame handshake, layout, parameter ack
// assumes binding to the framer top, single clock domain
`default_nettype none
module radar_framer_asserts (
  input wire logic        clk_sys, reset_n, clk_en, cycle_tick, frame_tx_ready,
  input wire logic        frame_tx_valid, object_valid, object_select, internal_error,
  input wire logic        param_wr, param_rd, param_ack, param_err,
  input wire logic [15:0] near_distance, frame_pgn,
  input wire logic [7:0]  near_azimuth, near_elevation, near_velocity, near_strength,
  input wire logic [5:0]  radius_hit,
  input wire logic [63:0] frame_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic start;
  logic take;
  assign start = clk_en && cycle_tick && !frame_tx_valid;
  assign take = clk_en && frame_tx_valid && frame_tx_ready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_pgn_constant: assert property (frame_pgn == 16'hff20)
    else $error("frame group code wrong");
  a_frame_offer: assert property (start |=> frame_tx_valid)
    else $error("tick did not raise valid");
  a_frame_hold: assert property (frame_tx_valid && !take |=> frame_tx_valid && $stable(frame_data))
    else $error("frame changed before taken");
  a_frame_drop: assert property (take |=> !frame_tx_valid)
    else $error("valid stayed after handshake");
  a_near_payload: assert property (start && !object_select |=> frame_data[47:0] ==
    {$past(near_strength), $past(near_velocity), $past(near_elevation),
     $past(near_azimuth), $past(near_distance)})
    else $error("measurement bytes wrong");
  a_flag_byte: assert property (start |=> frame_data[55:48] ==
    {$past(radius_hit), 1'b0, !$past(object_valid)})
    else $error("flag byte wrong");
  a_error_bit: assert property (start |=> frame_data[57:56] == {1'b0, $past(internal_error)})
    else $error("error bit wrong");
  a_param_ack: assert property (clk_en && (param_wr || param_rd) |=> param_ack)
    else $error("access not acknowledged");
  a_err_with_ack: assert property (param_err |-> param_ack)
    else $error("error without ack");
endmodule
`default_nettype wire

// >>> sim/can_sink.sv
// can side model: takes each offered frame, stalls while asked
// assumes the bench drives stall off the sampling edge
`default_nettype none
module can_sink (
  input  wire logic        clk_sys,
  input  wire logic        frame_tx_valid,
  input  wire logic [63:0] frame_data,
  input  wire logic        stall,
  output logic             frame_tx_ready,
  output logic [63:0]      last_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  assign frame_tx_ready = frame_tx_valid && !stall;
  always @(posedge clk_sys)
    if (frame_tx_ready)
      last_frame <= frame_data;
endmodule
`default_nettype wire

// >>> sim/radar_process_data_framer_test.sv
// bench: parameter bank through index access, frames through the can model
// assumes the framer, its checker and the can model compiled before it
`default_nettype none
module radar_process_data_framer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, clk_en, object_valid, internal_error, object_select, stall;
  logic cycle_tick, frame_tx_ready, frame_tx_valid, param_wr, param_rd, param_ack, param_err;
  logic [15:0] near_distance, strong_distance, frame_pgn, param_index, param_wdata, param_rdata;
  logic [15:0] idx, wd, ex, base [5];
  logic [7:0] near_azimuth, near_elevation, near_velocity, near_strength, param_subindex, sub;
  logic [7:0] strong_azimuth, strong_elevation, strong_velocity, strong_strength;
  logic [5:0] radius_hit;
  logic [2:0] field_shaded, field_collision;
  logic [63:0] frame_data, last_frame, exp_frame;
  logic [9:0] channel_mode;
  logic [4:0] channel_nc;
  int errors, checks_done, i, c, p;
  radar_process_data_framer dut_u (.*);
  can_sink sink_u (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ======================================
  // tasks
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // answer is registered on the taking edge and checked at the next falling edge
  task automatic access(input logic wr, input logic [15:0] exp, input logic ex_err);
    {param_wr, param_rd, param_index, param_subindex, param_wdata} = {wr, !wr, idx, sub, wd};
    @(negedge clk_sys);
    {param_wr, param_rd} = 2'b00;
    check(param_ack, 1'b1);
    check(param_err, ex_err);
    if (!wr)
      check(param_rdata, exp);
  endtask
  task automatic frame(input logic sel);
    logic [47:0] meas;
    int k;
    meas = sel ? {strong_strength, strong_velocity, strong_elevation, strong_azimuth,
      strong_distance} : {near_strength, near_velocity, near_elevation, near_azimuth,
      near_distance};
    exp_frame = {field_collision[2], field_shaded[2], field_collision[1], field_shaded[1],
      field_collision[0], field_shaded[0], 1'b0, internal_error, radius_hit, 1'b0,
      !object_valid, meas};
    {object_select, cycle_tick} = {sel, 1'b1};
    @(negedge clk_sys);
    cycle_tick = 1'b0;
    check(frame_tx_valid, 1'b1);
    check(frame_data, exp_frame);
    for (k = 0; k < 20 && frame_tx_valid !== 1'b0; k++)
      @(negedge clk_sys);
    if (k == 20)
    begin
      errors++;
      summarize;
    end
    check(last_frame, exp_frame);
  endtask
  // ======================================
  // sequence
  initial
  begin
    {clk_en, reset_n, stall, cycle_tick, param_wr, param_rd, idx, sub, wd} = {6'b100000, 40'h0};
    {near_distance, near_azimuth, near_elevation, near_velocity, near_strength} =
      48'hbeef_f6_14_b5_3f;
    {strong_distance, strong_azimuth, strong_elevation, strong_velocity, strong_strength} =
      48'h0102_7f_80_5a_32;
    {object_valid, internal_error, object_select, radius_hit, field_shaded, field_collision} =
      15'h6ae;
    base = '{16'h400e, 16'h401c, 16'h401e, 16'h402c, 16'h402e};
    errors = 0;
    checks_done = 0;
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    check({channel_mode, channel_nc}, 15'h0);
    check(frame_pgn, 16'hff20);
    for (p = 0; p < 2; p++)
      for (c = 0; c < 5; c++)
        for (i = 0; i < 5; i++)
        begin
          wd = {8'h5a, i[3:0], c[3:0]};
          ex = (i == 2) ? (wd & 16'h1) : (i == 3) ? (wd & 16'h3) : wd;
          idx = base[c] + 16'(i > 1);
          sub = (i > 1) ? 8'(i - 1) : 8'(i + 1);
          access(p == 0, ex, 1'b0);
        end
    check({channel_mode, channel_nc}, {10'h0e4, 5'h0a});
    {idx, sub, wd} = {16'h4010, 8'h01, 16'hffff};
    access(1'b1, 16'h0, 1'b1);
    access(1'b0, 16'h0, 1'b1);
    {idx, sub} = {16'h401d, 8'h00};
    access(1'b0, 16'h0, 1'b1);
    frame(1'b0);
    frame(1'b1);
    {object_valid, internal_error, radius_hit, field_shaded, field_collision} = 14'h0680;
    stall = 1'b1;
    fork
      frame(1'b1);
      begin
        repeat (3) @(negedge clk_sys);
        {strong_distance, cycle_tick} = {16'h1234, 1'b1};
        @(negedge clk_sys);
        cycle_tick = 1'b0;
        check(frame_data, exp_frame);
        stall = 1'b0;
      end
    join
    check(frame_tx_valid, 1'b0);
    summarize;
  end
endmodule
bind radar_process_data_framer radar_framer_asserts chk_u (.*);
`default_nettype wire
